// ---- hw/muldiv_ctrl.sv ----
// APB-controlled master that drives the arithmetic unit
`timescale 1ns/10ps
`default_nettype none
`include "muldiv_defines.svh"
module muldiv_ctrl
    import muldiv_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic        clk_en_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    muldiv_if.ctrl           link
);
    typedef struct packed {
        host_state_type st;
        logic [2:0]     step;
        logic           mode;
        logic [31:0]    opa;
        logic [15:0]    opb;
        logic [31:0]    res;
        logic [15:0]    rem;
        logic           busy;
        logic           done;
        logic           wr;
        logic           rd;
        logic [15:0]    addr;
        logic [15:0]    wdata;
    } ctrl_state_type;

    ctrl_state_type s_q;
    ctrl_state_type s_d;
    logic           acc;
    logic           wr_acc;

    assign acc       = psel_i && penable_i;
    assign wr_acc    = acc && pwrite_i;
    assign pready_o  = 1'b1;
    assign pslverr_o = 1'b0;

    always_comb begin
        s_d    = s_q;
        s_d.wr = 1'b0;
        s_d.rd = 1'b0;
        if (wr_acc) begin
            if (paddr_i == `APB_OPA_ADDR) begin
                s_d.opa = pwdata_i;
            end else if (paddr_i == `APB_OPB_ADDR) begin
                s_d.opb = pwdata_i[15:0];
            end else if (paddr_i == `APB_CTRL_ADDR && !s_q.busy) begin
                s_d.mode = pwdata_i[`MODE_BIT_POS];
                s_d.busy = pwdata_i[`RUN_BIT_POS];
                s_d.done = 1'b0;
                s_d.step = 3'd0;
                s_d.st   = pwdata_i[`RUN_BIT_POS] ? HS_BUS : HS_IDLE;
            end else if (paddr_i == `APB_STAT_ADDR && pwdata_i[1]) begin
                s_d.done = 1'b0;
            end
        end
        case (s_q.st)
            HS_IDLE: begin
            end
            HS_BUS: begin
                // Operands first, control last, as the unit expects
                s_d.wr = 1'b1; // RULE17 RULE20
                s_d.step = s_q.step + 3'd1;
                case (s_q.step)
                    3'd0: begin
                        s_d.addr  = `OPA_LOW_OFFSET;
                        s_d.wdata = s_q.opa[15:0];
                    end
                    3'd1: begin
                        s_d.addr  = `OPA_HIGH_OFFSET;
                        // Multiply: junk high half left for the unit's own clear on start; divide: dividend high half
                        s_d.wdata = s_q.opa[31:16]; // RULE5
                    end
                    3'd2: begin
                        s_d.addr  = `OPB_OFFSET;
                        s_d.wdata = s_q.opb; // RULE9
                    end
                    default: begin
                        s_d.addr  = `CTRL_OFFSET;
                        s_d.wdata = {8'h00, 1'b1, 6'h00, s_q.mode}; // RULE14 RULE18
                        s_d.st    = HS_WAIT;
                    end
                endcase
            end
            HS_WAIT: begin
                if (link.done_irq) begin
                    s_d.step = 3'd0;
                    s_d.st   = HS_DONE;
                end
            end
            HS_DONE: begin
                s_d.rd   = 1'b1;
                s_d.step = s_q.step + 3'd1;
                case (s_q.step)
                    3'd0: s_d.addr = `OPA_LOW_OFFSET;
                    3'd1: begin
                        s_d.res[15:0] = link.rdata;
                        s_d.addr      = `OPA_HIGH_OFFSET;
                    end
                    3'd2: begin
                        s_d.res[31:16] = link.rdata;
                        s_d.addr       = `REM_OFFSET;
                    end
                    default: begin
                        s_d.rem  = link.rdata;
                        s_d.rd   = 1'b0;
                        s_d.busy = 1'b0;
                        s_d.done = 1'b1;
                        s_d.st   = HS_IDLE;
                    end
                endcase
            end
            default: s_d.st = HS_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else if (clk_en_i) begin
            s_q <= s_d;
        end
    end

    always_comb begin
        prdata_o = 32'h0;
        if (paddr_i == `APB_CTRL_ADDR) begin
            prdata_o = {24'h0, s_q.busy, 6'h0, s_q.mode};
        end else if (paddr_i == `APB_OPA_ADDR) begin
            prdata_o = s_q.opa;
        end else if (paddr_i == `APB_OPB_ADDR) begin
            prdata_o = {16'h0, s_q.opb};
        end else if (paddr_i == `APB_RES_ADDR) begin
            prdata_o = s_q.res;
        end else if (paddr_i == `APB_REM_ADDR) begin
            prdata_o = {16'h0, s_q.rem};
        end else if (paddr_i == `APB_STAT_ADDR) begin
            prdata_o = {30'h0, s_q.done, s_q.busy};
        end
    end

    assign link.wr_en = s_q.wr;
    assign link.rd_en = s_q.rd;
    assign link.addr  = s_q.addr;
    assign link.size  = SIZE_WORD;
    assign link.wdata = s_q.wdata;
endmodule // muldiv_ctrl
`default_nettype wire

// ---- hw/muldiv_unit.sv ----
// Memory-mapped 16x16 multiplier and 32/16 divider
// Summary of operation
// RULE1: Unsigned 16x16 multiply, 32/16 divide with remainder.
// RULE2: Remainder register zero after multiply, remainder after divide.
// RULE3: Remainder cleared on reset and on start.
// RULE4: Operand/result register: operand in, result out.
// RULE5: Multiply start clears operand high half.
// RULE6: Operand registers hold intermediates while running.
// RULE7: Software leaves operands alone while running.
// RULE8: Second operand register holds multiplier/divisor, resets zero.
// RULE9: Software never divides by zero.
// RULE10: Control: run bit 7, mode bit 0, rest zero.
// RULE11: Mode bit 0 divides, 1 multiplies.
// RULE12: Writing run bit starts; hardware clears on completion.
// RULE13: Clearing run aborts; coinciding completion still valid.
// RULE14: Software keeps mode bit steady while running.
// RULE15: Multiply completes after exactly 16 clocks.
// RULE16: Result stored, run cleared, then interrupt raised.
// RULE17: Multiply: load operands, then write control 81.
// RULE18: After abort, reload everything and restart.
// RULE19: Operand registers take byte and word accesses.
// RULE20: Divide: load dividend and divisor, write control 80.
// RULE21: Divide completes after 32 clocks.
// RULE22: Operands unsigned; remainder smaller than divisor.
`timescale 1ns/10ps
`default_nettype none
`include "muldiv_defines.svh"
module muldiv_unit
    import muldiv_pkg::*;
(
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    input  wire logic clk_en_i,
    muldiv_if.unit    bus
);
    typedef struct packed {
        logic        run;
        logic        mode;
        logic [31:0] opa;
        logic [15:0] opb;
        logic [15:0] rem;
        logic [5:0]  cnt;
        logic        irq;
    } unit_state_type;

    unit_state_type s_q;
    unit_state_type s_d;
    logic [16:0]    trial;
    logic [15:0]    mask;
    logic [15:0]    wval;
    logic [15:0]    opl;
    logic [15:0]    oph;
    logic [15:0]    opb;
    logic           ctrl_wr;
    logic           finish;
    logic [5:0]     cnt_next;

    // Byte writes land on the lane picked by address bit 0; word writes take both
    always_comb begin
        if (bus.size == SIZE_WORD) begin // RULE19
            mask = 16'hffff;
            wval = bus.wdata;
        end else if (bus.addr[0]) begin
            mask = 16'hff00;
            wval = {bus.wdata[7:0], 8'h00};
        end else begin
            mask = 16'h00ff;
            wval = {8'h00, bus.wdata[7:0]};
        end
    end

    always_comb begin
        s_d      = s_q;
        opl      = (s_q.opa[15:0] & ~mask) | (wval & mask);
        oph      = (s_q.opa[31:16] & ~mask) | (wval & mask);
        opb      = (s_q.opb & ~mask) | (wval & mask);
        ctrl_wr  = bus.wr_en && (bus.addr == `CTRL_OFFSET);
        cnt_next = s_q.cnt + 6'd1;
        finish   = s_q.run && (cnt_next == (s_q.mode ? `MUL_CYCLES : `DIV_CYCLES)); // RULE15 RULE21
        trial    = {s_q.rem, s_q.opa[31]} - {1'b0, s_q.opb};
        s_d.irq  = 1'b0;
        // Second operand writes are honoured even while running, result then undefined; operand/result writes are overwritten by the step
        if (bus.wr_en) begin // RULE7
            if (bus.addr[15:1] == 15'(`OPA_LOW_OFFSET >> 1)) begin
                s_d.opa[15:0] = opl; // RULE4
            end else if (bus.addr[15:1] == 15'(`OPA_HIGH_OFFSET >> 1)) begin
                s_d.opa[31:16] = oph;
            end else if (bus.addr[15:1] == 15'(`OPB_OFFSET >> 1)) begin
                s_d.opb = opb; // RULE8
            end
        end
        if (s_q.run) begin
            s_d.cnt = cnt_next;
            if (s_q.mode) begin
                // Shift-add: low half holds multiplier bits, high half accumulates
                if (s_q.opa[0]) begin // RULE1 RULE6 RULE22
                    s_d.opa = {17'({1'b0, s_q.opa[31:16]} + {1'b0, s_q.opb}), s_q.opa[15:1]};
                end else begin
                    s_d.opa = {1'b0, s_q.opa[31:1]};
                end
                s_d.rem = `DATA_RESET; // RULE2
            end else begin
                // Restoring divide: remainder register is the partial remainder
                if (!trial[16]) begin // RULE1 RULE6 RULE22
                    s_d.rem = trial[15:0];
                    s_d.opa = {s_q.opa[30:0], 1'b1};
                end else begin
                    s_d.rem = {s_q.rem[14:0], s_q.opa[31]};
                    s_d.opa = {s_q.opa[30:0], 1'b0};
                end
            end
            if (finish) begin
                s_d.run = 1'b0; // RULE12 RULE16
                s_d.irq = 1'b1; // RULE16
            end
        end
        if (ctrl_wr) begin
            s_d.mode = bus.wdata[`MODE_BIT_POS]; // RULE10 RULE11
            if (bus.wdata[`RUN_BIT_POS] && !s_q.run) begin
                s_d.run = 1'b1; // RULE12
                s_d.cnt = 6'd0;
                s_d.rem = `DATA_RESET; // RULE3
                if (bus.wdata[`MODE_BIT_POS]) begin
                    s_d.opa[31:16] = `DATA_RESET; // RULE5
                end
            end else if (!bus.wdata[`RUN_BIT_POS] && !finish) begin
                // Completion in the same cycle wins, keeping the result valid
                s_d.run = 1'b0; // RULE13
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            s_q <= '0; // RULE3 RULE8 RULE10
        end else if (clk_en_i) begin
            s_q <= s_d;
        end
    end

    // Reads return registered state; unmapped addresses read zero
    always_comb begin
        bus.rdata = 16'h0000;
        if (bus.addr == `CTRL_OFFSET) begin
            bus.rdata = {8'h00, s_q.run, 6'h00, s_q.mode}; // RULE10
        end else if (bus.addr[15:1] == 15'(`OPA_LOW_OFFSET >> 1)) begin
            bus.rdata = s_q.opa[15:0];
        end else if (bus.addr[15:1] == 15'(`OPA_HIGH_OFFSET >> 1)) begin
            bus.rdata = s_q.opa[31:16];
        end else if (bus.addr[15:1] == 15'(`OPB_OFFSET >> 1)) begin
            bus.rdata = s_q.opb;
        end else if (bus.addr[15:1] == 15'(`REM_OFFSET >> 1)) begin
            bus.rdata = s_q.rem; // RULE2
        end
    end
    assign bus.done_irq = s_q.irq;
endmodule // muldiv_unit
`default_nettype wire

// ---- shared/muldiv_defines.svh ----
// Register offsets, field positions, reset values and timing counts of the arithmetic unit
`ifndef MULDIV_DEFINES_SVH
`define MULDIV_DEFINES_SVH
`define CTRL_OFFSET      16'hff68
`define OPA_LOW_OFFSET   16'hff60
`define OPA_HIGH_OFFSET  16'hff62
`define OPB_OFFSET       16'hff64
`define REM_OFFSET       16'hff66
`define RUN_BIT_POS      7
`define MODE_BIT_POS     0
`define CTRL_RESET       8'h00
`define DATA_RESET       16'h0000
`define MUL_CYCLES       6'd16
`define DIV_CYCLES       6'd32
`define APB_CTRL_ADDR    12'h000
`define APB_OPA_ADDR     12'h004
`define APB_OPB_ADDR     12'h008
`define APB_RES_ADDR     12'h00c
`define APB_REM_ADDR     12'h010
`define APB_STAT_ADDR    12'h014
`endif

// ---- shared/muldiv_if.sv ----
// Peripheral-bus link between the arithmetic unit and its controller
`timescale 1ns/10ps
`default_nettype none
interface muldiv_if;
    import muldiv_pkg::*;
    logic         wr_en;
    logic         rd_en;
    logic [15:0]  addr;
    acc_size_type size;
    logic [15:0]  wdata;
    logic [15:0]  rdata;
    logic         done_irq;
    modport unit (input wr_en, rd_en, addr, size, wdata, output rdata, done_irq);
    modport ctrl (output wr_en, rd_en, addr, size, wdata, input rdata, done_irq);
endinterface
`default_nettype wire

// ---- shared/muldiv_pkg.sv ----
// Types shared by both ends of the arithmetic unit link
package muldiv_pkg;
    typedef enum logic {
        SIZE_BYTE,
        SIZE_WORD
    } acc_size_type;
    typedef enum logic [1:0] {
        HS_IDLE,
        HS_BUS,
        HS_WAIT,
        HS_DONE
    } host_state_type;
endpackage

// ---- test/muldiv_monitor.sv ----
// Link checker for the multiplier/divider pair
`timescale 1ns/10ps
`default_nettype none
`include "muldiv_defines.svh"
module muldiv_monitor
    import muldiv_pkg::*;
(
    input wire logic         sys_clk_i,
    input wire logic         rst_i,
    input wire logic         wr_en,
    input wire logic         rd_en,
    input wire logic  [15:0] addr,
    input wire acc_size_type size,
    input wire logic  [15:0] wdata,
    input wire logic  [15:0] rdata,
    input wire logic         done_irq
);
    logic [15:0] opa_q;
    logic [15:0] opb_q;
    logic        mul_q;
    logic        fin_q;
    wire logic        ctl_wr = wr_en && addr == `CTRL_OFFSET;
    wire logic [31:0] prod   = opa_q * opb_q;
    // Results only judged once done and before the next write
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            opa_q <= 16'h0000;
            opb_q <= 16'h0000;
            mul_q <= 1'b0;
            fin_q <= 1'b0;
        end else begin
            if (wr_en && addr == `OPA_LOW_OFFSET) opa_q <= wdata;
            if (wr_en && addr == `OPB_OFFSET) opb_q <= wdata;
            if (ctl_wr) mul_q <= wdata[0];
            if (wr_en) fin_q <= 1'b0;
            else if (done_irq) fin_q <= 1'b1;
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    sequence s_mul_go; ctl_wr && wdata[7:0] == 8'h81; endsequence
    sequence s_div_go; ctl_wr && wdata[7:0] == 8'h80; endsequence
    sequence s_quiet; ##1 !done_irq [*8]; endsequence
    property p_mul_time; s_mul_go |-> s_quiet ##9 done_irq; endproperty
    property p_div_time; s_div_go |-> s_quiet ##25 done_irq; endproperty
    property p_irq_pulse; done_irq |=> !done_irq; endproperty
    property p_rst_quiet;
        @(posedge sys_clk_i) disable iff (1'b0) rst_i |=> !done_irq && !wr_en;
    endproperty
    property p_prod_low;
        fin_q && mul_q && !wr_en && addr == `OPA_LOW_OFFSET |-> rdata == prod[15:0];
    endproperty
    property p_prod_high;
        fin_q && mul_q && !wr_en && addr == `OPA_HIGH_OFFSET |-> rdata == prod[31:16];
    endproperty
    property p_mul_rem;
        fin_q && mul_q && !wr_en && addr == `REM_OFFSET |-> rdata == 16'h0000;
    endproperty
    property p_div_rem;
        fin_q && !mul_q && !wr_en && addr == `REM_OFFSET && opb_q != 16'h0000
            |-> rdata < opb_q;
    endproperty
    a_mul_time: assert property (p_mul_time) else $error("multiply finish time off");
    a_div_time: assert property (p_div_time) else $error("divide finish time off");
    a_irq_pulse: assert property (p_irq_pulse) else $error("done pulse too long");
    a_rst_quiet: assert property (p_rst_quiet) else $error("activity in reset");
    a_prod_low: assert property (p_prod_low) else $error("product low wrong");
    a_prod_high: assert property (p_prod_high) else $error("product high wrong");
    a_mul_rem: assert property (p_mul_rem) else $error("remainder not zero");
    a_div_rem: assert property (p_div_rem) else $error("remainder too big");
endmodule // muldiv_monitor
`default_nettype wire

// ---- test/testbench.sv ----
// Self-checking bench for the APB-driven multiplier/divider pair
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import muldiv_pkg::*;
    logic        sys_clk_i;
    logic        rst_i;
    logic        psel_i;
    logic        penable_i;
    logic        pwrite_i;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic [31:0] rd;
    logic [31:0] rd_q;
    int          err_count;
    int          cmp_count;
    muldiv_if link();
    muldiv_unit i_muldiv_unit (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .clk_en_i(1'b1),
        .bus(link));
    muldiv_ctrl i_muldiv_ctrl (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .clk_en_i(1'b1),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .link(link));
    muldiv_monitor i_muldiv_monitor (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .wr_en(link.wr_en), .rd_en(link.rd_en), .addr(link.addr), .size(link.size),
        .wdata(link.wdata), .rdata(link.rdata), .done_irq(link.done_irq));
    // Read data taken at the completing edge, not after it
    always @(posedge sys_clk_i) begin
        if (psel_i && penable_i && pready_o) rd_q <= prdata_o;
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // Idle edge after each transfer keeps strobes from being set twice at once
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel_i   <= 1'b1;
        pwrite_i <= wr;
        paddr_i  <= a;
        pwdata_i <= d;
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        do @(posedge sys_clk_i); while (pready_o !== 1'b1);
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        @(posedge sys_clk_i);
        rd = rd_q;
    endtask
    task automatic finish_op();
        int n;
        n = 0;
        do begin
            apb(1'b0, 12'h014, 32'h0);
            n++;
        end while (rd[1] !== 1'b1 && n < 60);
        check("done flag", 32'h1, {31'h0, rd[1]});
    endtask
    task automatic clear_done();
        apb(1'b1, 12'h014, 32'h0000_0002);
        apb(1'b0, 12'h014, 32'h0);
        check("status after clear", 32'h0, rd & 32'h3);
    endtask
    task automatic test_reset();
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, 12'(4 * i), 32'h0);
            check("reset value", 32'h0, rd);
        end
        apb(1'b0, 12'h3f0, 32'h0);
        check("unmapped error", 32'h0, {31'h0, pslverr_o});
        $display("test_reset done");
    endtask
    task automatic test_mul();
        logic [15:0] a[4] = '{16'hffff, 16'h0000, 16'h0001, 16'h1234};
        logic [15:0] b[4] = '{16'hffff, 16'h1234, 16'hffff, 16'h5678};
        for (int i = 0; i < 4; i++) begin
            // Junk high half must be cleared by the start
            apb(1'b1, 12'h004, {16'hdead, a[i]});
            apb(1'b1, 12'h008, {16'h0000, b[i]});
            apb(1'b1, 12'h000, 32'h0000_0081);
            apb(1'b1, 12'h000, 32'h0000_0080);
            apb(1'b0, 12'h014, 32'h0);
            check("busy flag", 32'h1, {31'h0, rd[0]});
            finish_op();
            apb(1'b0, 12'h00c, 32'h0);
            check("product", a[i] * b[i], rd);
            apb(1'b0, 12'h010, 32'h0);
            check("mul remainder", 32'h0, rd);
            clear_done();
        end
        $display("test_mul done");
    endtask
    task automatic test_div();
        logic [31:0] n[4] = '{32'hdcba2586, 32'hffffffff, 32'h00000005, 32'h80000000};
        logic [15:0] d[4] = '{16'h0018, 16'hffff, 16'h0007, 16'h0001};
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 12'h004, n[i]);
            apb(1'b1, 12'h008, {16'h0000, d[i]});
            apb(1'b1, 12'h000, 32'h0000_0080);
            finish_op();
            apb(1'b0, 12'h00c, 32'h0);
            check("quotient", n[i] / d[i], rd);
            apb(1'b0, 12'h010, 32'h0);
            check("div remainder", n[i] % d[i], rd);
            clear_done();
        end
        $display("test_div done");
    endtask
    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    // Tests need a few thousand cycles at most
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        err_count++;
        summarize();
    end
    initial begin
        rst_i     = 1'b1;
        psel_i    = 1'b0;
        penable_i = 1'b0;
        pwrite_i  = 1'b0;
        paddr_i   = 12'h000;
        pwdata_i  = 32'h0;
        err_count = 0;
        cmp_count = 0;
        repeat (8) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        @(posedge sys_clk_i);
        test_reset();
        test_mul();
        test_div();
        summarize();
    end
endmodule // testbench
`default_nettype wire
